//--- rtl/cirt_pkg.sv
// Package for cable interrupt routing and time snapshot block
package cirt_pkg;
    localparam logic [11:0] ADDR_ROUTE_A  = 12'h080;
    localparam logic [11:0] ADDR_ROUTE_B  = 12'h084;
    localparam logic [11:0] ADDR_ROUTE_C  = 12'h088;
    localparam logic [11:0] ADDR_PPS_CAP  = 12'h200;
    localparam logic [11:0] ADDR_CBL_CAP  = 12'h210;
    localparam logic [11:0] ADDR_MST_SEC  = 12'h220;
    localparam logic [11:0] ADDR_ERR_CLR  = 12'h400;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h300;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h304;
    localparam logic [11:0] ADDR_ERR_STAT = 12'h308;

    localparam int NUM_CABLE = 12;
    localparam int CODE_W    = 6;
    localparam int FLD_STEP  = 8;
    localparam int FLD_PER_R = 4;
    localparam int NUM_SRC   = 33;
    localparam int NS_W      = 30;

    // Source codes
    localparam logic [5:0] CODE_GPS = 6'h20;

    // Interrupt status bits
    localparam int IRQ_PPS = 0;
    localparam int IRQ_MST = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_W   = 3;

    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cirt_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] seconds;
        logic        error;
    } cirt_cable_rx_t;
endpackage : cirt_pkg

//--- rtl/cirt_src_sel.sv
// Decodes one routing source code into the selected source level
module cirt_src_sel (
    // Selection
    input  wire logic [5:0]  code,
    // Sources
    input  wire logic [7:0]  timer_irq,
    input  wire logic [11:0] edge_irq,
    input  wire logic [11:0] programmed_interrupt_generator,
    input  wire logic        gps_second_pulse,
    // Result
    output logic             sel_out
);
    logic [1:0] bank;
    logic [1:0] idx;

    always_comb begin
        bank    = code[5:4];
        idx     = code[1:0];
        sel_out = 1'b0;
        // [RULE2] Code decode
        if (code == cirt_pkg::CODE_GPS) begin
            sel_out = gps_second_pulse;
        end else if (bank != 2'h3) begin
            case (code[3:2])
                2'h1: begin
                    if (bank != 2'h2) begin
                        sel_out = timer_irq[{bank[0], idx}];
                    end
                end
                2'h2: sel_out = edge_irq[4'(bank) * 4'h4 + 4'(idx)];
                2'h3: sel_out =
                    programmed_interrupt_generator[4'(bank) * 4'h4 + 4'(idx)];
                default: sel_out = 1'b0;
            endcase
        end
    end
endmodule : cirt_src_sel

//--- rtl/cirt_core.sv
// Cable interrupt routing, time snapshots and cable error clearing
// Summary of operation
// [RULE1] Three routing registers select the sources driven onto the cable.
// [RULE2] Codes select timers, edge inputs, generators or the GPS pulse.
// [RULE3] Twelve fields sit in ascending order, unused bits read zero.
// [RULE4] The pulse capture holds nanoseconds and two seconds bits.
// [RULE5] The pulse capture loads on every GPS pulse event.
// [RULE6] The cable capture has the same format as the pulse capture.
// [RULE7] The cable capture loads on every received master-time message.
// [RULE8] The master seconds register shows seconds received from the cable.
// [RULE9] The master board sends its seconds at each whole-second boundary.
// [RULE10] Any write to the error clear register clears reported errors; an error arriving in the same cycle stays set.
// [RULE11] The written value is ignored; only the write clears.
//
// Decided for this implementation: the strobed register port.
module cirt_core (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port
    input  wire cirt_pkg::cirt_bus_req_t bus,
    output logic [31:0]                  rdata,
    // Local sources
    input  wire logic [7:0]              timer_irq,
    input  wire logic [11:0]             edge_irq,
    input  wire logic [11:0]             programmed_interrupt_generator,
    input  wire logic                    gps_second_pulse,
    // Running clock
    input  wire logic [31:0]             posix_sec,
    input  wire logic [29:0]             posix_ns,
    // Cable receive side
    input  wire cirt_pkg::cirt_cable_rx_t cable_rx,
    // Cable and interrupt outputs
    output logic [11:0]                  cable_irq,
    output logic                         cable_error,
    output logic                         irq
);
    typedef struct packed {
        logic [5:0][5:0]  fld;
        logic [5:0][5:0]  fld_b;
        logic [31:0]      pps_cap;
        logic [31:0]      cbl_cap;
        logic [31:0]      mst_sec;
        logic [2:0]       stat;
        logic [2:0]       mask;
        logic             err;
        logic             gps_d;
        logic [11:0]      cirq;
        logic [31:0]      rdata;
        logic             irq;
    } cirt_state_t;

    cirt_state_t s_r;
    cirt_state_t s_nxt;
    logic [11:0][5:0] codes;
    logic [11:0]      sel;

    // Unpack fields in ascending cable order
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            codes[i]     = s_r.fld[i];
            codes[i + 6] = s_r.fld_b[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < cirt_pkg::NUM_CABLE; g++) begin : g_sel
            cirt_src_sel u_sel (
                .code                           (codes[g]),
                .timer_irq                      (timer_irq),
                .edge_irq                       (edge_irq),
                .programmed_interrupt_generator (programmed_interrupt_generator),
                .gps_second_pulse               (gps_second_pulse),
                .sel_out                        (sel[g])
            );
        end
    endgenerate

    function automatic logic [31:0] pack_route(
        input logic [11:0][5:0] c, input int base, input int n);
        logic [31:0] v;
        v = cirt_pkg::ZERO32;
        for (int k = 0; k < 4; k++) begin
            if (k < n) begin
                v[k*cirt_pkg::FLD_STEP +: cirt_pkg::CODE_W] = c[base + k];
            end
        end
        return v;
    endfunction : pack_route

    logic        wr_hit;
    logic [2:0]  ev;
    logic [31:0] snap;

    always_comb begin
        s_nxt  = s_r;
        wr_hit = bus.wr;
        // [RULE4] Nanoseconds with two seconds bits
        snap   = {posix_sec[1:0], posix_ns};
        ev     = 3'h0;
        // [RULE1] Routed levels to cable
        s_nxt.cirq  = sel;
        s_nxt.gps_d = gps_second_pulse;

        // [RULE5] Capture on pulse edge
        if (gps_second_pulse && !s_r.gps_d) begin
            s_nxt.pps_cap = snap;
            ev[cirt_pkg::IRQ_PPS] = 1'b1;
        end
        // [RULE7] Capture on master message
        if (cable_rx.valid) begin
            // [RULE6] Same capture format
            s_nxt.cbl_cap = snap;
            // [RULE8] Received master seconds
            s_nxt.mst_sec = cable_rx.seconds;
            ev[cirt_pkg::IRQ_MST] = 1'b1;
        end

        if (wr_hit) begin
            case (bus.addr)
                // [RULE3] Fields at byte lanes
                cirt_pkg::ADDR_ROUTE_A: begin
                    for (int k = 0; k < 4; k++) begin
                        s_nxt.fld[k] = bus.wdata[k*8 +: 6];
                    end
                end
                cirt_pkg::ADDR_ROUTE_B: begin
                    s_nxt.fld[4] = bus.wdata[5:0];
                    s_nxt.fld[5] = bus.wdata[13:8];
                    s_nxt.fld_b[0] = bus.wdata[21:16];
                    s_nxt.fld_b[1] = bus.wdata[29:24];
                end
                cirt_pkg::ADDR_ROUTE_C: begin
                    for (int k = 0; k < 4; k++) begin
                        s_nxt.fld_b[k + 2] = bus.wdata[k*8 +: 6];
                    end
                end
                cirt_pkg::ADDR_IRQ_MASK: s_nxt.mask = bus.wdata[2:0];
                cirt_pkg::ADDR_IRQ_STAT:
                    s_nxt.stat = s_r.stat & ~bus.wdata[2:0];
                // [RULE10] Clear reported errors
                // [RULE11] Data ignored
                cirt_pkg::ADDR_ERR_CLR: s_nxt.err = 1'b0;
                default: s_nxt.err = s_nxt.err;
            endcase
        end
        // Error set wins over clear
        if (cable_rx.error) begin
            s_nxt.err = 1'b1;
            ev[cirt_pkg::IRQ_ERR] = 1'b1;
        end
        s_nxt.stat = s_nxt.stat | ev;
        s_nxt.irq  = |(s_nxt.stat & s_nxt.mask);

        s_nxt.rdata = cirt_pkg::ZERO32;
        if (bus.rd) begin
            case (bus.addr)
                cirt_pkg::ADDR_ROUTE_A: s_nxt.rdata = pack_route(codes, 0, 4);
                cirt_pkg::ADDR_ROUTE_B: s_nxt.rdata = pack_route(codes, 4, 4);
                cirt_pkg::ADDR_ROUTE_C: s_nxt.rdata = pack_route(codes, 8, 4);
                cirt_pkg::ADDR_PPS_CAP:  s_nxt.rdata = s_r.pps_cap;
                cirt_pkg::ADDR_CBL_CAP:  s_nxt.rdata = s_r.cbl_cap;
                cirt_pkg::ADDR_MST_SEC:  s_nxt.rdata = s_r.mst_sec;
                cirt_pkg::ADDR_IRQ_STAT: s_nxt.rdata = {29'h0, s_r.stat};
                cirt_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {29'h0, s_r.mask};
                cirt_pkg::ADDR_ERR_STAT: s_nxt.rdata = {31'h0, s_r.err};
                default:                 s_nxt.rdata = cirt_pkg::ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata       = s_r.rdata;
    assign cable_irq   = s_r.cirq;
    assign cable_error = s_r.err;
    assign irq         = s_r.irq;
endmodule : cirt_core

//--- tb/cirt_core_asserts.sv
// Checker on reads, captures and cable error clearing
module cirt_core_asserts (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Watched ports
    input wire cirt_pkg::cirt_bus_req_t  bus,
    input wire logic [31:0]              rdata,
    input wire logic                     gps_second_pulse,
    input wire logic [31:0]              posix_sec,
    input wire logic [29:0]              posix_ns,
    input wire cirt_pkg::cirt_cable_rx_t cable_rx,
    input wire logic                     cable_error
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cap(ev, a);
        ev ##1 (bus.rd && bus.addr == a && !ev);
    endsequence
    sequence s_clr;
        bus.wr && bus.addr == 12'h400 && !cable_rx.error;
    endsequence
    property p_pps;
        s_cap($rose(gps_second_pulse), 12'h200) |=>
            rdata == {$past(posix_sec[1:0], 2), $past(posix_ns, 2)};
    endproperty
    property p_cbl;
        s_cap(cable_rx.valid, 12'h210) |=>
            rdata == {$past(posix_sec[1:0], 2), $past(posix_ns, 2)};
    endproperty
    property p_mst;
        s_cap(cable_rx.valid, 12'h220) |=>
            rdata == $past(cable_rx.seconds, 2);
    endproperty
    property p_clr;
        s_clr and bus.wdata == 32'h0 |=> !cable_error;
    endproperty
    property p_clr_any;
        s_clr and bus.wdata != 32'h0 |=> !cable_error;
    endproperty
    property p_err;
        $rose(cable_error) |-> $past(cable_rx.error);
    endproperty
    property p_wo;
        bus.rd && bus.addr == 12'h400 |=> rdata == 32'h0;
    endproperty
    property p_route;
        bus.rd && bus.addr[11:4] == 8'h08 && bus.addr[3:2] != 2'h3
            |=> (rdata & 32'hC0C0_C0C0) == 32'h0;
    endproperty
    a_pps: assert property (p_pps) else $error("pulse capture");
    a_cbl: assert property (p_cbl) else $error("cable capture");
    a_mst: assert property (p_mst) else $error("master secs");
    a_clr: assert property (p_clr) else $error("clear");
    a_clr_any: assert property (p_clr_any) else $error("clear");
    a_err: assert property (p_err) else $error("stray error");
    a_wo: assert property (p_wo) else $error("clear readable");
    a_route: assert property (p_route) else $error("route bits");
endmodule : cirt_core_asserts
bind cirt_core cirt_core_asserts u_chk (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .gps_second_pulse(gps_second_pulse),
    .posix_sec(posix_sec), .posix_ns(posix_ns), .cable_rx(cable_rx),
    .cable_error(cable_error));

//--- tb/cirt_peer.sv
// Far-end board model sending master seconds and faults
module cirt_peer (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Bench commands
    input wire logic                 tick,
    input wire logic                 err,
    // Cable toward the block
    output cirt_pkg::cirt_cable_rx_t rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sec_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            sec_r <= 32'h0;
            rx    <= '0;
        end else begin
            rx.valid <= tick;
            rx.error <= err;
            sec_r      <= sec_r + 32'(tick);
            rx.seconds <= tick ? sec_r + 32'h1 : ~rx.seconds;
        end
    end
endmodule : cirt_peer

//--- tb/test_cirt_core.sv
// Bench for cable routing, time captures and error clearing
module test_cirt_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk = 1'b0, rst = 1'b1, tick = 1'b0;
    logic                     err = 1'b0, cable_error, irq;
    logic [32:0]              src = '0;
    logic [31:0]              posix_sec = 32'h6, rdata;
    logic [29:0]              posix_ns = 30'h123_4567;
    logic [11:0]              cable_irq;
    logic [5:0]               c;
    logic [5:0]               rsv [4] = '{6'h00, 6'h13, 6'h21, 6'h3F};
    cirt_pkg::cirt_bus_req_t  bus = '0;
    cirt_pkg::cirt_cable_rx_t cable_rx;
    int                       bad_count = 0, n_tests = 0, i, k;
    always #5 clk = ~clk;
    cirt_core dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .timer_irq(src[7:0]), .edge_irq(src[19:8]),
        .programmed_interrupt_generator(src[31:20]),
        .gps_second_pulse(src[32]), .posix_sec(posix_sec),
        .posix_ns(posix_ns), .cable_rx(cable_rx),
        .cable_irq(cable_irq), .cable_error(cable_error), .irq(irq));
    cirt_peer peer (.clk(clk), .rst(rst), .tick(tick), .err(err),
        .rx(cable_rx));
    task chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task rd(logic [11:0] a, logic [31:0] e, string nm);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask : rd
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(12'h080, 32'h0, "route");
        wr(12'h088, 32'hFFFF_FFFF);
        rd(12'h088, 32'h3F3F_3F3F, "route");
        for (int j = 0; j < 37; j++) begin
            k = (j < 8) ? 0 : (j < 20) ? 1 : 2;
            i = j - ((k == 0) ? 0 : (k == 1) ? 8 : 20);
            c = 6'(4 * (k + 1) + 16 * (i / 4) + i % 4);
            if (j == 32) c = 6'h20;
            if (j > 32) c = rsv[j - 33];
            for (int r = 0; r < 3; r++) wr(12'h080 + 12'(4 * r), {4{2'h0, c}});
            src <= (j > 32) ? '1 : 33'h1 << j;
            repeat (2) @(posedge clk);
            #1 chk("fan", 32'(cable_irq), (j > 32) ? 32'h0 : 32'hFFF);
        end
        wr(12'h080, 32'h0706_0504);
        wr(12'h084, 32'h1716_1514);
        wr(12'h088, 32'h0B0A_0908);
        src <= 33'h481;
        repeat (2) @(posedge clk);
        #1 chk("order", 32'(cable_irq), 32'h481);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            posix_ns <= posix_ns + 30'h5;
            posix_sec <= posix_sec + 32'h1;
            @(posedge clk);
            // Read in the cycle right after the pulse edge is taken
            src <= 33'h1_0000_0000;
            rd(12'h200, {posix_sec[1:0], posix_ns}, "pps");
            @(posedge clk);
            src <= '0;
        end
        #1 chk("irq", 32'(irq), 32'h0);
        wr(12'h304, 32'h1);
        @(posedge clk);
        #1 chk("irq", 32'(irq), 32'h1);
        wr(12'h300, 32'h1);
        @(posedge clk);
        #1 chk("irq", 32'(irq), 32'h0);
        for (int p = 1; p < 3; p++) begin
            @(posedge clk);
            posix_ns <= posix_ns + 30'h9;
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            // Right after the message, each register read first once
            for (int q = 0; q < 2; q++) begin
                if ((q == 0) == (p == 1)) begin
                    rd(12'h210, {posix_sec[1:0], posix_ns}, "cbl");
                end else begin
                    rd(12'h220, 32'(p), "master");
                end
            end
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            err <= 1'b1;
            @(posedge clk);
            err <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk("err", 32'(cable_error), 32'h1);
            rd(12'h308, 32'h1, "err_stat");
            wr(12'h400, p ? 32'hFFFF_FFFF : 32'h0);
            #1 chk("clr", 32'(cable_error), 32'h0);
        end
        // Error arriving with the clear stays reported
        @(posedge clk);
        err <= 1'b1;
        wr(12'h400, 32'h0);
        err <= 1'b0;
        #1 chk("set_wins", 32'(cable_error), 32'h1);
        wr(12'h400, 32'h0);
        #1 chk("clr", 32'(cable_error), 32'h0);
        rd(12'h300, 32'h6, "status");
        wr(12'h304, 32'h6);
        @(posedge clk);
        #1 chk("irq", 32'(irq), 32'h1);
        rd(12'h400, 32'h0, "wo");
        rd(12'h004, 32'h0, "unmapped");
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim;
    end
endmodule : test_cirt_core
